// >>> pkg/sat_pkg.sv
/*
  Constants for the rule table indirect access block: register addresses,
  indirect offsets, field positions, masks and reset values.
  Assumes a byte-wide management register port on the switch core clock.
*/
package sat_pkg;

  // ****************************************
  // Management register addresses
  // ****************************************
  localparam logic [7:0] SAT_ADDR_SELECT = 8'h6e;
  localparam logic [7:0] SAT_ADDR_OFFSET = 8'h6f;
  localparam logic [7:0] SAT_ADDR_DATA = 8'ha0;

  // ****************************************
  // Select register fields
  // ****************************************
  localparam logic [2:0] SAT_TABLE_ACL = 3'b010;
  localparam int SAT_SEL_DIR_BIT = 4;
  localparam logic [3:0] SAT_PORT_FIRST = 4'h1;
  localparam logic [7:0] SAT_REG_RESET = 8'h00;

  // ****************************************
  // Indirect offsets within one port
  // ****************************************
  localparam logic [7:0] SAT_OFS_PROC = 8'h00;
  localparam logic [7:0] SAT_OFS_MATCH = 8'h01;
  localparam logic [7:0] SAT_OFS_LAST_BYTE = 8'h0d;
  localparam logic [7:0] SAT_OFS_BE_HI = 8'h10;
  localparam logic [7:0] SAT_OFS_BE_LO = 8'h11;
  localparam logic [7:0] SAT_OFS_CTRL = 8'h12;
  localparam int SAT_ENTRY_BYTES = 14;
  localparam int SAT_BE_TOP = 15;
  localparam int SAT_RULE_TABLES = 5;

  // ****************************************
  // Entry field layout
  // ****************************************
  localparam logic [7:0] SAT_PROC_MASK = 8'h0f;
  localparam logic [7:0] SAT_MATCH_MASK = 8'h3f;
  localparam logic [7:0] SAT_BYTE_MASK = 8'hff;
  localparam int SAT_MD_LSB = 4;

  // ****************************************
  // Entry control byte fields
  // ****************************************
  localparam int SAT_CTRL_DIR_BIT = 4;
  localparam int SAT_CTRL_START_BIT = 5;
  localparam int SAT_CTRL_DONE_BIT = 6;

  typedef enum logic [1:0] {
    SAT_LAYER_OFF = 2'b00,
    SAT_LAYER_MAC = 2'b01,
    SAT_LAYER_IP = 2'b10,
    SAT_LAYER_PORT = 2'b11
  } sat_layer_t;

endpackage

// >>> core/sat_rule_access.sv
/*
  Indirect access path to the per-port rule tables: select, offset and data
  byte registers, per-port staging bytes, byte enables and entry control.
  Assumes the serial management logic drives the register port on clock_in.
*/
// How it works
// - Tables are reached only through the select, offset and data byte registers.
// - Each port's table holds sixteen entries; one table per port, four with the default PORTS.
// - Select bits 3..0 give the port number, indirect address 11..8.
// - Offset register's full byte gives indirect address 7..0.
// - Offsets 0..13 map to entry bytes 15 down to 2.
// - Offsets 14 and 15 are reserved and carry no content.
// - Offsets 16 and 17 hold the per-bit byte-enable mask.
// - Offset 18 is the entry control and status byte.
// - Select bits 7..5 equal to 010 pick the rule table.
// - Offset 0 bits 3..0 hold first rule index, reset zero, upper zero.
// - Offsets 12 and 13 group rules into a multi-rule set.
// - Offset 1 bits 5..4 select filter layer, reset 00, upper zero.
// - Writing the offset register triggers the selected operation; here only a read starts on it, a write waits for the data byte write.
// - Select bit 4 set means read, clear means write.
`timescale 1ns/100ps
module sat_rule_access #(
  parameter int PORTS = 4,
  parameter int ENTRIES = 16
) (
  input wire logic clock_in, // Core clock
  input wire logic reset_in, // Async reset, high
  input wire logic reg_write_in, // Register write strobe
  input wire logic reg_read_in, // Register read strobe
  input wire logic [7:0] reg_addr_in, // Register address
  input wire logic [7:0] reg_wdata_in, // Write data
  output logic [7:0] reg_rdata_out, // Read data
  output logic reg_rvalid_out, // Read data valid pulse
  input wire logic [$clog2(PORTS)-1:0] lookup_port_in, // Filter lookup port
  input wire logic [$clog2(ENTRIES)-1:0] lookup_entry_in, // Filter lookup entry
  output logic [3:0] first_rule_index_out, // Looked-up first rule
  output sat_pkg::sat_layer_t filter_layer_select_out // Looked-up layer
);
  import sat_pkg::*;

  localparam int PW = $clog2(PORTS);
  localparam int EW = $clog2(ENTRIES);

  logic [7:0] sel_q;
  logic [7:0] ofs_q;
  logic [7:0] data_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic op_go_q;
  logic [PW-1:0] op_port_q;
  logic [7:0] stage_q [PORTS][SAT_ENTRY_BYTES];
  logic [15:0] be_q [PORTS];
  logic [EW-1:0] idx_q [PORTS];
  logic dir_q [PORTS];
  logic done_q [PORTS];
  logic [7:0] mem_q [PORTS][ENTRIES][SAT_ENTRY_BYTES];
  logic [3:0] fri_q;
  sat_layer_t layer_q;

  logic sel_acl;
  logic port_ok;
  logic [PW-1:0] port_idx;
  logic ofs_is_byte;
  logic trig;
  logic data_wr;
  logic [7:0] rd_val;

  function automatic logic [7:0] byte_mask(input logic [7:0] ofs);
    byte_mask = SAT_BYTE_MASK;
    if (ofs == SAT_OFS_PROC) begin
      byte_mask = SAT_PROC_MASK;
    end else if (ofs == SAT_OFS_MATCH) begin
      byte_mask = SAT_MATCH_MASK;
    end
  endfunction

  // ****************************************
  // Indirect address decode
  // ****************************************
  assign sel_acl = sel_q[7:5] == SAT_TABLE_ACL;
  assign port_ok = sel_q[3:0] >= SAT_PORT_FIRST && sel_q[3:0] <= 4'(PORTS);
  assign port_idx = PW'(sel_q[3:0] - SAT_PORT_FIRST);
  assign ofs_is_byte = ofs_q <= SAT_OFS_LAST_BYTE;
  assign trig = reg_write_in && reg_addr_in == SAT_ADDR_OFFSET;
  assign data_wr = reg_write_in && reg_addr_in == SAT_ADDR_DATA && wr_pend_q
    && sel_acl && port_ok;

  always_comb begin
    rd_val = 8'h00;
    if (sel_acl && port_ok) begin
      if (ofs_is_byte) begin
        rd_val = stage_q[port_idx][ofs_q[3:0]] & byte_mask(ofs_q);
      end else if (ofs_q == SAT_OFS_BE_HI) begin
        rd_val = be_q[port_idx][15:8];
      end else if (ofs_q == SAT_OFS_BE_LO) begin
        rd_val = be_q[port_idx][7:0];
      end else if (ofs_q == SAT_OFS_CTRL) begin
        rd_val = 8'h00;
        rd_val[SAT_CTRL_DONE_BIT] = done_q[port_idx];
        rd_val[SAT_CTRL_DIR_BIT] = dir_q[port_idx];
        rd_val[3:0] = 4'(idx_q[port_idx]);
      end
    end
  end

  // ****************************************
  // Select, offset and data byte registers
  // ****************************************
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sel_q <= SAT_REG_RESET;
      ofs_q <= SAT_REG_RESET;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= 1'b0;
      if (reg_write_in && reg_addr_in == SAT_ADDR_SELECT) begin
        sel_q <= reg_wdata_in;
        wr_pend_q <= 1'b0;
      end
      if (trig) begin
        ofs_q <= reg_wdata_in;
        rd_pend_q <= sel_q[SAT_SEL_DIR_BIT] && sel_acl;
        wr_pend_q <= !sel_q[SAT_SEL_DIR_BIT];
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      data_q <= SAT_REG_RESET;
    end else if (rd_pend_q) begin
      data_q <= rd_val;
    end else if (data_wr) begin
      data_q <= reg_wdata_in & byte_mask(ofs_q);
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= SAT_REG_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_read_in;
      if (reg_read_in) begin
        unique case (reg_addr_in)
          SAT_ADDR_SELECT: rdata_q <= sel_q;
          SAT_ADDR_OFFSET: rdata_q <= ofs_q;
          SAT_ADDR_DATA: rdata_q <= data_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  // ****************************************
  // Per-port staging, byte enables, control
  // ****************************************
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      for (int p = 0; p < PORTS; p++) begin
        for (int b = 0; b < SAT_ENTRY_BYTES; b++) begin
          stage_q[p][b] <= SAT_REG_RESET;
        end
        be_q[p] <= 16'h0000;
        idx_q[p] <= '0;
        dir_q[p] <= 1'b0;
        done_q[p] <= 1'b0;
      end
    end else begin
      if (op_go_q && dir_q[op_port_q]) begin
        for (int b = 0; b < SAT_ENTRY_BYTES; b++) begin
          stage_q[op_port_q][b] <= mem_q[op_port_q][idx_q[op_port_q]][b]
            & byte_mask(8'(b));
        end
      end
      if (data_wr && ofs_is_byte) begin
        stage_q[port_idx][ofs_q[3:0]] <= reg_wdata_in & byte_mask(ofs_q);
      end
      if (data_wr && ofs_q == SAT_OFS_BE_HI) begin
        be_q[port_idx][15:8] <= reg_wdata_in;
      end
      if (data_wr && ofs_q == SAT_OFS_BE_LO) begin
        be_q[port_idx][7:0] <= reg_wdata_in;
      end
      if (data_wr && ofs_q == SAT_OFS_CTRL) begin
        idx_q[port_idx] <= reg_wdata_in[EW-1:0];
        dir_q[port_idx] <= reg_wdata_in[SAT_CTRL_DIR_BIT];
        if (reg_wdata_in[SAT_CTRL_START_BIT]) begin
          done_q[port_idx] <= 1'b0;
        end
      end
      if (op_go_q) begin
        done_q[op_port_q] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      op_go_q <= 1'b0;
      op_port_q <= '0;
    end else begin
      op_go_q <= data_wr && ofs_q == SAT_OFS_CTRL && reg_wdata_in[SAT_CTRL_START_BIT];
      op_port_q <= port_idx;
    end
  end

  // ****************************************
  // Rule table storage
  // ****************************************
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      for (int p = 0; p < PORTS; p++) begin
        for (int e = 0; e < ENTRIES; e++) begin
          for (int b = 0; b < SAT_ENTRY_BYTES; b++) begin
            mem_q[p][e][b] <= SAT_REG_RESET;
          end
        end
      end
    end else if (op_go_q && !dir_q[op_port_q]) begin
      for (int b = 0; b < SAT_ENTRY_BYTES; b++) begin
        if (be_q[op_port_q][4'(SAT_BE_TOP - b)]) begin
          mem_q[op_port_q][idx_q[op_port_q]][b] <= stage_q[op_port_q][b];
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      fri_q <= 4'h0;
      layer_q <= SAT_LAYER_OFF;
    end else begin
      fri_q <= mem_q[lookup_port_in][lookup_entry_in][SAT_OFS_PROC[3:0]][3:0];
      layer_q <= sat_layer_t'(
        mem_q[lookup_port_in][lookup_entry_in][SAT_OFS_MATCH[3:0]][SAT_MD_LSB +: 2]);
    end
  end

  assign first_rule_index_out = fri_q;
  assign filter_layer_select_out = layer_q;

  // ****************************************
  // Checks
  // ****************************************
  AST_PORT_FIELD: assert property (@(posedge clock_in) disable iff (reset_in)
    reg_write_in && reg_addr_in == SAT_ADDR_SELECT |=> sel_q[3:0] == $past(reg_wdata_in[3:0]))
    else $error("port field not taken from select write");
  AST_OFFSET_FIELD: assert property (@(posedge clock_in) disable iff (reset_in)
    trig |=> ofs_q == $past(reg_wdata_in))
    else $error("offset not taken from offset write");
  AST_READ_TRIGGER: assert property (@(posedge clock_in) disable iff (reset_in)
    trig && sel_q[SAT_SEL_DIR_BIT] && sel_acl |=> ##1 data_q == $past(rd_val))
    else $error("read trigger did not load data byte");
  AST_WRITE_DIR: assert property (@(posedge clock_in) disable iff (reset_in)
    trig |=> wr_pend_q == !$past(sel_q[SAT_SEL_DIR_BIT]))
    else $error("direction bit not honoured");
  AST_OTHER_TABLE: assert property (@(posedge clock_in) disable iff (reset_in)
    !sel_acl && !rd_pend_q && reg_write_in && reg_addr_in == SAT_ADDR_DATA
      |=> data_q == $past(data_q))
    else $error("data byte changed while another table was selected");
  AST_PROC_RSV: assert property (@(posedge clock_in) disable iff (reset_in)
    sel_acl && port_ok && ofs_q == SAT_OFS_PROC |-> rd_val[7:4] == 4'h0)
    else $error("first rule byte upper bits not zero");
  AST_MATCH_RSV: assert property (@(posedge clock_in) disable iff (reset_in)
    sel_acl && port_ok && ofs_q == SAT_OFS_MATCH |-> rd_val[7:6] == 2'b00)
    else $error("layer byte upper bits not zero");
  AST_RSV_OFFSET: assert property (@(posedge clock_in) disable iff (reset_in)
    ofs_q > SAT_OFS_LAST_BYTE && ofs_q < SAT_OFS_BE_HI |-> rd_val == 8'h00)
    else $error("reserved offset returned data");
  AST_DONE_SET: assert property (@(posedge clock_in) disable iff (reset_in)
    data_wr && ofs_q == SAT_OFS_CTRL && reg_wdata_in[SAT_CTRL_START_BIT]
      |=> ##1 done_q[$past(port_idx, 2)])
    else $error("entry operation did not complete in two cycles");

endmodule // sat_rule_access

// >>> bench/sat_host_model.sv
/*
  Host model: drives the management register port with byte writes and reads,
  and the select, offset, data sequences that reach the rule tables.
  Assumes one clock, strobes taken on the rising edge, read answer a cycle later.
*/
`timescale 1ns/100ps
module sat_host_model (
  input wire logic clock_in, // Core clock
  input wire logic [7:0] rdata_in, // Read data
  input wire logic rvalid_in, // Read data valid
  output logic write_out, // Write strobe
  output logic read_out, // Read strobe
  output logic [7:0] addr_out, // Register address
  output logic [7:0] wdata_out // Write data
);
  initial begin
    write_out = 1'h0;
    read_out = 1'h0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  // Released lines show the inverse, never the stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    write_out = 1'h1;
    addr_out = a;
    wdata_out = d;
    @(posedge clock_in);
    #1;
    write_out = 1'h0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    #1;
    read_out = 1'h1;
    addr_out = a;
    @(posedge clock_in);
    #1;
    read_out = 1'h0;
    addr_out = ~a;
    d = rvalid_in ? rdata_in : 8'hxx;
  endtask

  task automatic raw(input logic [7:0] sel, input logic [7:0] o, input logic [7:0] v);
    wr(8'h6e, sel);
    wr(8'h6f, o);
    wr(8'ha0, v);
  endtask

  // Write one indirect byte of port p
  task automatic tw(input logic [3:0] p, input logic [7:0] o, input logic [7:0] v);
    raw({3'h2, 1'h0, p}, o, v);
  endtask

  // Read one indirect byte of port p
  task automatic tr(input logic [3:0] p, input logic [7:0] o, output logic [7:0] d);
    wr(8'h6e, {3'h2, 1'h1, p});
    wr(8'h6f, o);
    rd(8'ha0, d);
  endtask
endmodule // sat_host_model

// >>> bench/tb.sv
/*
  Self-checking bench for the rule table access block.
  Assumes the host model drives the register port and the bench the lookup side.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import sat_pkg::*;
  logic clock_in = 1'h0;
  logic reset_in = 1'h1;
  logic reg_write, reg_read, rvalid;
  logic [7:0] addr, wdata, rdata, d;
  logic [1:0] lookup_port = 2'h0;
  logic [3:0] lookup_entry = 4'h0;
  logic [3:0] first_rule;
  sat_layer_t layer;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #10 clock_in = ~clock_in;

  sat_rule_access #(.PORTS(4), .ENTRIES(16)) dut (.clock_in(clock_in), .reset_in(reset_in),
    .reg_write_in(reg_write), .reg_read_in(reg_read), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .lookup_port_in(lookup_port), .lookup_entry_in(lookup_entry),
    .first_rule_index_out(first_rule), .filter_layer_select_out(layer));

  sat_host_model host (.clock_in(clock_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .write_out(reg_write), .read_out(reg_read), .addr_out(addr), .wdata_out(wdata));

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic look(input logic [1:0] p, input logic [3:0] e, input logic [3:0] f,
                      input logic [1:0] m);
    @(posedge clock_in);
    #1;
    lookup_port = p;
    lookup_entry = e;
    repeat (2) @(posedge clock_in);
    #1;
    `CHK(first_rule, f)
    `CHK(layer, sat_layer_t'(m))
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    look(2'h0, 4'h0, 4'h0, 2'h0);
    host.tr(4'h1, SAT_OFS_PROC, d);
    `CHK(d, SAT_REG_RESET)
    host.tr(4'h1, SAT_OFS_MATCH, d);
    `CHK(d, SAT_REG_RESET)
    host.rd(8'h55, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_fields();
    logic [7:0] ofs [7] = '{8'h00, 8'h01, 8'h0e, 8'h0f, 8'h13, 8'h02, 8'h0d};
    logic [7:0] val [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'ha5, 8'h5a};
    logic [7:0] exp [7] = '{8'h0f, 8'h3f, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h5a};
    for (int i = 0; i < 7; i++) begin
      host.tw(4'h1, ofs[i], val[i]);
      host.tr(4'h1, ofs[i], d);
      `CHK(d, exp[i])
    end
  endtask

  // Every layer code, one port each, top entries
  task automatic t_commit();
    logic [3:0] idx;
    logic [3:0] p;
    logic [1:0] code;
    for (int c = 0; c < 4; c++) begin
      code = c[1:0];
      p = {2'h0, code} + 4'h1;
      idx = 4'hf - {2'h0, code};
      host.tw(p, SAT_OFS_PROC, {4'h0, idx});
      host.tw(p, SAT_OFS_MATCH, {2'h0, code, 4'h0});
      host.tw(p, SAT_OFS_BE_HI, 8'hc0);
      host.tw(p, SAT_OFS_BE_LO, 8'h00);
      host.tw(p, SAT_OFS_CTRL, {4'h2, idx});
      host.tr(p, SAT_OFS_CTRL, d);
      `CHK(d, {4'h4, idx})
      look(code, idx, idx, code);
    end
    look(2'h0, 4'he, 4'h0, 2'h0);
  endtask

  // Masked write with layer and last bytes enabled, then read back
  task automatic t_enable();
    host.tw(4'h1, SAT_OFS_PROC, 8'h05);
    host.tw(4'h1, SAT_OFS_MATCH, 8'h20);
    host.tw(4'h1, SAT_OFS_BE_HI, 8'h40);
    host.tw(4'h1, SAT_OFS_BE_LO, 8'h04);
    host.tw(4'h1, SAT_OFS_CTRL, 8'h23);
    look(2'h0, 4'h3, 4'h0, 2'h2);
    host.tw(4'h1, SAT_OFS_PROC, 8'h09);
    host.tw(4'h1, SAT_OFS_LAST_BYTE, 8'h00);
    host.tw(4'h1, SAT_OFS_CTRL, 8'h33);
    host.tr(4'h1, SAT_OFS_PROC, d);
    `CHK(d, 8'h00)
    host.tr(4'h1, SAT_OFS_MATCH, d);
    `CHK(d, 8'h20)
    host.tr(4'h1, SAT_OFS_LAST_BYTE, d);
    `CHK(d, 8'h5a)
    host.tr(4'h1, SAT_OFS_BE_HI, d);
    `CHK(d, 8'h40)
  endtask

  // Wrong table, ports 0 and 5, read direction: data writes dropped
  task automatic t_refuse();
    host.raw(8'h61, SAT_OFS_PROC, 8'h0a);
    host.raw(8'h40, SAT_OFS_PROC, 8'h0a);
    host.raw(8'h45, SAT_OFS_PROC, 8'h0a);
    host.raw(8'h51, SAT_OFS_PROC, 8'h0b);
    host.tr(4'h1, SAT_OFS_PROC, d);
    `CHK(d, 8'h00)
    host.tr(4'h4, SAT_OFS_PROC, d);
    `CHK(d, 8'h0c)
    host.rd(SAT_ADDR_SELECT, d);
    `CHK(d, 8'h54)
    host.rd(SAT_ADDR_OFFSET, d);
    `CHK(d, SAT_OFS_PROC)
  endtask

  initial begin
    repeat (5) @(posedge clock_in);
    #1;
    reset_in = 1'h0;
    t_reset();
    t_fields();
    t_commit();
    t_enable();
    t_refuse();
    summarize();
  end
endmodule // tb
